// *** core/cvc_pkg.sv ***
// shared constants for the converter voltage code register slice
package cvc_pkg;

  // register bank port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 7;
  localparam int MV_W   = 12;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFF_CONV4_SLEEP  = 8'h95;
  localparam logic [7:0] OFF_CONV5_NORMAL = 8'h96;
  localparam logic [7:0] OFF_CONV5_SLEEP  = 8'h97;
  localparam logic [7:0] OFF_CONV6_NORMAL = 8'h98;

  ////////////////////////////////////////////////////////////////////////
  // field layout inside each register
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 1;
  localparam int FALL_BIT = 0;

  // step size of one code count, in mV, per range
  localparam logic [11:0] STEP_FINE_MV   = 12'h00A;
  localparam logic [11:0] STEP_COARSE_MV = 12'h019;

  // answer to a read of an offset outside this slice
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // factory reset patterns, indexed by device option 0..3
  localparam int NUM_OPTIONS = 4;
  localparam logic [7:0] RST_CONV4_SLEEP  [NUM_OPTIONS] = '{8'h28, 8'h00, 8'hE8, 8'hA8};
  localparam logic [7:0] RST_CONV5_NORMAL [NUM_OPTIONS] = '{8'h70, 8'hE8, 8'h40, 8'hE8};
  localparam logic [7:0] RST_CONV5_SLEEP  [NUM_OPTIONS] = '{8'h70, 8'hE8, 8'h40, 8'hE8};
  localparam logic [7:0] RST_CONV6_NORMAL [NUM_OPTIONS] = '{8'hBE, 8'hDC, 8'h70, 8'h58};

endpackage

// *** core/cvc_vreg.sv ***
`timescale 1ns/1ps
`default_nettype none

// one 8-bit voltage code register with a factory reset pattern
module cvc_vreg #(
  parameter logic [7:0] RESET_VALUE   = 8'h00,
  parameter bit         FALL_BIT_USED = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output var  logic [7:0] value
);

  // a reserved low bit is forced to zero on every load path
  localparam logic [7:0] KEEP_MASK = FALL_BIT_USED ? 8'hFF : 8'hFE;

  wire logic [7:0] next_value;

  // mask applied here to the write path; the reset load applies it again on its own
  assign next_value = wrData & KEEP_MASK; // RL8

  ////////////////////////////////////////////////////////////////////////
  // storage
  always_ff @(posedge clk) begin
    if (rst) begin
      value <= RESET_VALUE & KEEP_MASK; // RL7
    end else if (wrEn) begin
      value <= next_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_reset_pattern_load: // RL7
    assert property (@(posedge clk) rst |=> (value == (RESET_VALUE & KEEP_MASK)))
      else $error("register did not load its factory pattern");

  a_reserved_bit_zero: // RL8
    assert property (@(posedge clk) disable iff (rst)
      (!FALL_BIT_USED && wrEn && wrData[0]) |=> (value[0] == 1'b0))
      else $error("reserved bit took a written one");

  a_value_holds_idle:
    assert property (@(posedge clk) disable iff (rst)
      (!wrEn && !$past(rst)) |=> (value == $past(value)))
      else $error("register changed without a write");

endmodule

`default_nettype wire

// *** core/cvc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RL1] offset 95h bits 7:1 hold the fourth converter's sleep code, read-write
// [RL2] offset 96h bits 7:1 hold the fifth converter's normal code, read-write
// [RL3] offset 97h bits 7:1 hold the fifth converter's sleep code, read-write
// [RL4] offset 98h bits 7:1 hold the sixth converter's normal code, read-write
// [RL5] bit 0 of normal registers: 0 slews down actively, 1 decays passively
// [RL6] each code counts in 10 mV or 25 mV steps per converter range
// [RL7] after reset each register holds its device option's factory pattern
// [RL8] bit 0 of sleep registers is reserved, reads zero, ignores writes
module cvc_regs #(
  parameter int DEVICE_OPTION = 0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        range4Coarse,
  input  wire logic        range5Coarse,
  input  wire logic        range6Coarse,
  output var  logic [7:0]  regRdData,
  output var  logic        regRdValid,
  output logic      [6:0]  conv4SleepCode,
  output logic      [6:0]  conv5NormalCode,
  output logic      [6:0]  conv5SleepCode,
  output logic      [6:0]  conv6NormalCode,
  output logic             conv5PassiveFallSel,
  output logic             conv6PassiveFallSel,
  output var  logic [11:0] conv4SleepDeltaMv,
  output var  logic [11:0] conv5NormalDeltaMv,
  output var  logic [11:0] conv5SleepDeltaMv,
  output var  logic [11:0] conv6NormalDeltaMv
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // code times step size; 127 * 25 = 3175 still fits 12 bits
  function automatic logic [11:0] stepDelta(input logic [6:0] code, input logic coarse);
    logic [11:0] step;
    step = coarse ? cvc_pkg::STEP_COARSE_MV : cvc_pkg::STEP_FINE_MV;
    return {5'h00, code} * step;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire logic       hitC4Sleep;
  wire logic       hitC5Normal;
  wire logic       hitC5Sleep;
  wire logic       hitC6Normal;
  wire logic       hitAny;
  wire logic [7:0] valC4Sleep;
  wire logic [7:0] valC5Normal;
  wire logic [7:0] valC5Sleep;
  wire logic [7:0] valC6Normal;
  wire logic [7:0] next_regRdData;

  assign hitC4Sleep  = (regAddr == cvc_pkg::OFF_CONV4_SLEEP);  // RL1
  assign hitC5Normal = (regAddr == cvc_pkg::OFF_CONV5_NORMAL); // RL2
  assign hitC5Sleep  = (regAddr == cvc_pkg::OFF_CONV5_SLEEP);  // RL3
  assign hitC6Normal = (regAddr == cvc_pkg::OFF_CONV6_NORMAL); // RL4
  assign hitAny      = hitC4Sleep | hitC5Normal | hitC5Sleep | hitC6Normal;

  ////////////////////////////////////////////////////////////////////////
  // the four registers; sleep ones keep no low bit at all
  cvc_vreg #(
    .RESET_VALUE   (cvc_pkg::RST_CONV4_SLEEP[DEVICE_OPTION]), // RL7
    .FALL_BIT_USED (1'b0)                                     // RL8
  ) u_conv4Sleep (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (regWrEn & hitC4Sleep), // RL1
    .wrData (regWrData),
    .value  (valC4Sleep)
  );

  cvc_vreg #(
    .RESET_VALUE   (cvc_pkg::RST_CONV5_NORMAL[DEVICE_OPTION]), // RL7
    .FALL_BIT_USED (1'b1)                                      // RL5
  ) u_conv5Normal (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (regWrEn & hitC5Normal), // RL2
    .wrData (regWrData),
    .value  (valC5Normal)
  );

  cvc_vreg #(
    .RESET_VALUE   (cvc_pkg::RST_CONV5_SLEEP[DEVICE_OPTION]), // RL7
    .FALL_BIT_USED (1'b0)                                     // RL8
  ) u_conv5Sleep (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (regWrEn & hitC5Sleep), // RL3
    .wrData (regWrData),
    .value  (valC5Sleep)
  );

  cvc_vreg #(
    .RESET_VALUE   (cvc_pkg::RST_CONV6_NORMAL[DEVICE_OPTION]), // RL7
    .FALL_BIT_USED (1'b1)                                      // RL5
  ) u_conv6Normal (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (regWrEn & hitC6Normal), // RL4
    .wrData (regWrData),
    .value  (valC6Normal)
  );

  ////////////////////////////////////////////////////////////////////////
  // field taps straight off the register flops
  assign conv4SleepCode      = valC4Sleep[cvc_pkg::CODE_MSB:cvc_pkg::CODE_LSB];  // RL1
  assign conv5NormalCode     = valC5Normal[cvc_pkg::CODE_MSB:cvc_pkg::CODE_LSB]; // RL2
  assign conv5SleepCode      = valC5Sleep[cvc_pkg::CODE_MSB:cvc_pkg::CODE_LSB];  // RL3
  assign conv6NormalCode     = valC6Normal[cvc_pkg::CODE_MSB:cvc_pkg::CODE_LSB]; // RL4
  assign conv5PassiveFallSel = valC5Normal[cvc_pkg::FALL_BIT];                   // RL5
  assign conv6PassiveFallSel = valC6Normal[cvc_pkg::FALL_BIT];                   // RL5

  // read mux; a read in the same cycle as a write sees the old value
  assign next_regRdData = hitC4Sleep  ? valC4Sleep  :
                          hitC5Normal ? valC5Normal :
                          hitC5Sleep  ? valC5Sleep  :
                          hitC6Normal ? valC6Normal :
                          cvc_pkg::UNMAPPED_DATA;

  ////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdData  <= regRdEn ? next_regRdData : 8'h00;
      regRdValid <= regRdEn;
    end
  end

  // step scaling is registered so the outputs leave from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      conv4SleepDeltaMv  <= 12'h000;
      conv5NormalDeltaMv <= 12'h000;
      conv5SleepDeltaMv  <= 12'h000;
      conv6NormalDeltaMv <= 12'h000;
    end else begin
      conv4SleepDeltaMv  <= stepDelta(conv4SleepCode, range4Coarse);  // RL6
      conv5NormalDeltaMv <= stepDelta(conv5NormalCode, range5Coarse); // RL6
      conv5SleepDeltaMv  <= stepDelta(conv5SleepCode, range5Coarse);  // RL6
      conv6NormalDeltaMv <= stepDelta(conv6NormalCode, range6Coarse); // RL6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_conv4_sleep_write: // RL1
    assert property (@(posedge clk) disable iff (rst)
      (regWrEn && regAddr == cvc_pkg::OFF_CONV4_SLEEP)
        |=> (conv4SleepCode == $past(regWrData[7:1])))
      else $error("fourth converter sleep code not written");

  a_conv5_normal_write: // RL2
    assert property (@(posedge clk) disable iff (rst)
      (regWrEn && regAddr == cvc_pkg::OFF_CONV5_NORMAL)
        |=> (conv5NormalCode == $past(regWrData[7:1])))
      else $error("fifth converter normal code not written");

  a_conv5_sleep_read: // RL3
    assert property (@(posedge clk) disable iff (rst)
      (regRdEn && !regWrEn && regAddr == cvc_pkg::OFF_CONV5_SLEEP)
        |=> (regRdValid && regRdData == {conv5SleepCode, 1'b0}))
      else $error("fifth converter sleep read mismatch");

  a_conv6_normal_read: // RL4
    assert property (@(posedge clk) disable iff (rst)
      (regRdEn && !regWrEn && regAddr == cvc_pkg::OFF_CONV6_NORMAL)
        |=> (regRdData == {conv6NormalCode, conv6PassiveFallSel}))
      else $error("sixth converter normal read mismatch");

  a_fall_select_write: // RL5
    assert property (@(posedge clk) disable iff (rst)
      (regWrEn && regAddr == cvc_pkg::OFF_CONV5_NORMAL)
        |=> (conv5PassiveFallSel == $past(regWrData[0])))
      else $error("fifth converter fall select not written");

  // delta lags code and range by one edge, so a write in between must not trip this
  a_step_delta_scale: // RL6
    assert property (@(posedge clk) disable iff (rst)
      !$past(rst)
        |=> (conv6NormalDeltaMv == 12'($past(conv6NormalCode)) *
             ($past(range6Coarse) ? cvc_pkg::STEP_COARSE_MV : cvc_pkg::STEP_FINE_MV)))
      else $error("sixth converter step scaling wrong");

  a_reset_conv5_normal: // RL7
    assert property (@(posedge clk)
      rst |=> ({conv5NormalCode, conv5PassiveFallSel} == cvc_pkg::RST_CONV5_NORMAL[DEVICE_OPTION]))
      else $error("fifth converter normal reset pattern wrong");

  a_conv4_reserved_read: // RL8
    assert property (@(posedge clk) disable iff (rst)
      (regRdEn && regAddr == cvc_pkg::OFF_CONV4_SLEEP) |=> (regRdData[0] == 1'b0))
      else $error("reserved bit read as one");

  a_unmapped_read_zero:
    assert property (@(posedge clk) disable iff (rst)
      (regRdEn && !hitAny) |=> (regRdValid && regRdData == cvc_pkg::UNMAPPED_DATA))
      else $error("unmapped read not zero");

  a_conv5_sleep_write: // RL3
    assert property (@(posedge clk) disable iff (rst)
      (regWrEn && regAddr == cvc_pkg::OFF_CONV5_SLEEP)
        |=> (conv5SleepCode == $past(regWrData[7:1])))
      else $error("fifth converter sleep code not written");

  a_conv6_normal_write: // RL4
    assert property (@(posedge clk) disable iff (rst)
      (regWrEn && regAddr == cvc_pkg::OFF_CONV6_NORMAL)
        |=> ({conv6NormalCode, conv6PassiveFallSel} == $past(regWrData)))
      else $error("sixth converter normal register not written");

  // answer idles at zero so a host polling late never sees stale data
  a_read_valid_pulse:
    assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> (regRdValid == $past(regRdEn)) && (regRdValid || regRdData == 8'h00))
      else $error("read answer not a one-cycle pulse");

endmodule

`default_nettype wire

// *** dv/cvc_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// register host model on the strobe port, drives 1 ns after the edge
module cvc_host (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid,
  output var  logic       regWrEn,
  output var  logic       regRdEn,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData
);
  // idle lines carry the inverse of the last value so stale data never passes
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // one-cycle write strobe
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    regWrEn = 1'b1;
    regAddr = addr;
    regWrData = data;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    regAddr = ~addr;
    regWrData = ~data;
  endtask

  // one-cycle read strobe; the answer stands only in the following cycle
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(posedge clk);
    #1;
    regRdEn = 1'b1;
    regAddr = addr;
    @(posedge clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~addr;
    valid = regRdValid;
    data = regRdData;
  endtask
endmodule

`default_nettype wire

// *** dv/cvc_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module cvc_regs_bench;
  localparam int OPT = 2;
  logic        clk, rst, range4Coarse, range5Coarse, range6Coarse;
  logic        regWrEn, regRdEn, regRdValid, rdValid;
  logic [7:0]  regAddr, regWrData, regRdData, addr, data, rdData;
  logic [6:0]  conv4SleepCode, conv5NormalCode, conv5SleepCode, conv6NormalCode;
  logic        conv5PassiveFallSel, conv6PassiveFallSel;
  logic [11:0] conv4SleepDeltaMv, conv5NormalDeltaMv, conv5SleepDeltaMv, conv6NormalDeltaMv;
  logic [7:0]  shadow [4];
  int          errTotal, testsRun, seed;

  cvc_regs #(.DEVICE_OPTION(OPT)) i_cvc_regs (
    .clk(clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .range4Coarse(range4Coarse), .range5Coarse(range5Coarse),
    .range6Coarse(range6Coarse), .regRdData(regRdData), .regRdValid(regRdValid),
    .conv4SleepCode(conv4SleepCode), .conv5NormalCode(conv5NormalCode),
    .conv5SleepCode(conv5SleepCode), .conv6NormalCode(conv6NormalCode),
    .conv5PassiveFallSel(conv5PassiveFallSel), .conv6PassiveFallSel(conv6PassiveFallSel),
    .conv4SleepDeltaMv(conv4SleepDeltaMv), .conv5NormalDeltaMv(conv5NormalDeltaMv),
    .conv5SleepDeltaMv(conv5SleepDeltaMv), .conv6NormalDeltaMv(conv6NormalDeltaMv));

  cvc_host i_cvc_host (
    .clk(clk), .regRdData(regRdData), .regRdValid(regRdValid), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));

  ////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [7:0] resetImage(input int slot);
    case (slot)
      0: return cvc_pkg::RST_CONV4_SLEEP[OPT];
      1: return cvc_pkg::RST_CONV5_NORMAL[OPT];
      2: return cvc_pkg::RST_CONV5_SLEEP[OPT];
      default: return cvc_pkg::RST_CONV6_NORMAL[OPT];
    endcase
  endfunction

  // sleep slots keep bit 0 at zero whatever is written
  function automatic logic [7:0] afterWrite(input int slot, input logic [7:0] d);
    return (slot == 0 || slot == 2) ? {d[7:1], 1'b0} : d;
  endfunction

  function automatic logic [11:0] expMv(input logic [6:0] code, input logic coarse);
    return 12'(code) * (coarse ? 12'h019 : 12'h00A);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a >= 8'h95 && a <= 8'h98;
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // reads every slot back, then compares the code, select and step outputs
  task automatic checkAll();
    for (int s = 0; s < 4; s++) begin
      i_cvc_host.rd(8'h95 + 8'(s), rdData, rdValid);
      chk(12'(rdValid), 12'h001);
      chk(12'(rdData), 12'(shadow[s]));
    end
    chk(12'(conv4SleepCode), 12'(shadow[0][7:1]));
    chk(12'(conv5NormalCode), 12'(shadow[1][7:1]));
    chk(12'(conv5SleepCode), 12'(shadow[2][7:1]));
    chk(12'(conv6NormalCode), 12'(shadow[3][7:1]));
    chk(12'(conv5PassiveFallSel), 12'(shadow[1][0]));
    chk(12'(conv6PassiveFallSel), 12'(shadow[3][0]));
    chk(conv4SleepDeltaMv, expMv(shadow[0][7:1], range4Coarse));
    chk(conv5NormalDeltaMv, expMv(shadow[1][7:1], range5Coarse));
    chk(conv5SleepDeltaMv, expMv(shadow[2][7:1], range5Coarse));
    chk(conv6NormalDeltaMv, expMv(shadow[3][7:1], range6Coarse));
  endtask

  task automatic reportAndStop();
    $display("mismatches %0d of %0d compares", errTotal, testsRun);
    if (errTotal == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the run needs well under 2000 cycles
  always #10 clk = ~clk;

  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    reportAndStop();
  end

  // main sequence: reset image, corner patterns, random traffic, reset again at the end
  initial begin
    seed = 33214;
    errTotal = 0;
    testsRun = 0;
    clk = 1'b0;
    rst = 1'b1;
    {range4Coarse, range5Coarse, range6Coarse} = 3'b000;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int s = 0; s < 4; s++) shadow[s] = resetImage(s);
    checkAll();
    foreach (shadow[s]) begin
      for (int p = 0; p < 3; p++) begin
        data = (p == 0) ? 8'hFF : (p == 1) ? 8'h00 : 8'h01;
        i_cvc_host.wr(8'h95 + 8'(s), data);
        shadow[s] = afterWrite(s, data);
        checkAll();
      end
    end
    for (int n = 0; n < 60; n++) begin
      addr = 8'h93 + 8'($unsigned($random(seed)) % 8);
      data = 8'($random(seed));
      {range4Coarse, range5Coarse, range6Coarse} = 3'($random(seed));
      i_cvc_host.wr(addr, data);
      if (mapped(addr)) shadow[addr - 8'h95] = afterWrite(int'(addr - 8'h95), data);
      i_cvc_host.rd(addr, rdData, rdValid);
      chk(12'(rdData), mapped(addr) ? 12'(shadow[addr - 8'h95]) : 12'h000);
    end
    checkAll();
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int s = 0; s < 4; s++) shadow[s] = resetImage(s);
    checkAll();
    reportAndStop();
  end
endmodule

`default_nettype wire
